/* File: shared/sar_adc_defines.vh */
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH
// Register indices; byte address is four times the index
`define RESULT_IDX 10'h070
`define CTRL_STATUS_IDX 10'h071
`define IRQ_STATUS_IDX 10'h072
`define IRQ_MASK_IDX 10'h073
// Control/status field positions
`define DONE_BIT 7
`define ON_BIT 5
`define CHAN_MSB 3
`define CHAN_LSB 0
// Reset values
`define RESULT_RESET 8'h00
`define CTRL_RESET 8'h00
`define IRQ_MASK_RESET 1'b0
// Timing, in converter clocks (one converter clock is two CPU clocks)
`define SAMPLE_TICKS 4'h4
`define CONV_TICKS 4'hC
`define SAR_FIRST 8'h80
`endif

/* File: sim/sar_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Comparator on the selected input against the trial code
module sar_adc_model (
   input wire logic [127:0] levels,
   input wire logic [3:0] channel_select,
   input wire logic [7:0] dac_code,
   input wire logic converter_on,
   output logic comp_in
);
   // Answers 1 when powered down; the sequencer builds no result while off
   assign comp_in = !converter_on ||
      levels[{channel_select, 3'b000} +: 8] >= dac_code;
endmodule // sar_adc_model
`default_nettype wire

/* File: sim/sar_adc_sequencer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Sequencer port checker
module sar_adc_checker (
   input wire ref_clk, input wire rst, input wire psel, input wire penable,
   input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata,
   input wire halt_mode, input wire [3:0] channel_select, input wire converter_on,
   input wire sample_connect, input wire [7:0] dac_code
);
   wire wr = psel && penable && pwrite && paddr == 12'h1C4;
   wire on_wr = wr && pwdata[5] && !halt_mode;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   property p_start; on_wr |=> sample_connect && converter_on && dac_code == 8'h00; endproperty
   a_start: assert property (p_start) else $error("no restart");
   property p_stop; wr && !pwdata[5] |=> !converter_on && !sample_connect; endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_idle; !converter_on && !$past(converter_on) |-> dac_code == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("code while off");
   property p_halt; halt_mode && $past(halt_mode) |-> !converter_on && !sample_connect; endproperty
   a_halt: assert property (p_halt) else $error("running in halt");
   property p_chan; wr |=> channel_select == $past(pwdata[3:0]); endproperty
   a_chan: assert property (p_chan) else $error("bad channel");
   // A restart stretches sampling, so only its minimum is bounded
   property p_samp; $fell(sample_connect) && converter_on |-> $past(sample_connect, 8);
   endproperty
   a_samp: assert property (p_samp) else $error("short sampling");
   property p_trial; $fell(sample_connect) && converter_on |-> dac_code == 8'h80; endproperty
   a_trial: assert property (p_trial) else $error("bad first trial");
   property p_loop; $rose(sample_connect) && $past(converter_on) && !$past(wr)
      |-> !$past(sample_connect, 16) && $past(sample_connect, 17); endproperty
   a_loop: assert property (p_loop) else $error("bad conversion length");
   cover property (on_wr && converter_on && !sample_connect);
   cover property ($rose(sample_connect) && $past(converter_on));
   cover property (halt_mode && $past(converter_on));
endmodule // sar_adc_checker
bind sar_adc_sequencer sar_adc_checker chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .halt_mode, .channel_select, .converter_on, .sample_connect, .dac_code);
`default_nettype wire

/* File: sim/test_sar_adc_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %0h got %0h", s, e, g); end end
module test_sar_adc_sequencer;
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic halt_mode = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [127:0] levels = 128'h0;
   wire pready, pslverr, comp_in, converter_on, sample_connect, irq;
   wire [31:0] prdata;
   wire [3:0] channel_select;
   wire [7:0] dac_code;
   int mismatches = 0, compares = 0, n;
   always #2.5 ref_clk = ~ref_clk;
   sar_adc_sequencer dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .halt_mode, .comp_in, .channel_select, .converter_on,
      .sample_connect, .dac_code, .irq);
   sar_adc_model model (.levels, .channel_select, .dac_code, .converter_on, .comp_in);
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bound(input int c);
      if (c >= 60) begin
         mismatches++;
         finish_test();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do @(posedge ref_clk) k++; while (pready !== 1'b1 && k < 60);
      bound(k);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fall(output int k);
      k = 0;
      while (sample_connect !== 1'b1 && k < 60) @(negedge ref_clk) k++;
      while (sample_connect !== 1'b0 && k < 60) @(negedge ref_clk) k++;
      bound(k);
   endtask
   task automatic convert(input logic [3:0] ch, input logic [7:0] lv);
      levels[{ch, 3'b000} +: 8] = lv;
      apb(1'b1, 12'h1C4, {24'h0, 4'h2, ch});
      n = 0;
      do apb(1'b0, 12'h1C4, 32'h0); while (rd[7] !== 1'b1 && n++ < 60);
      bound(n);
      `CHK("csr", {24'h0, 4'hA, ch}, rd)
      apb(1'b0, 12'h1C0, 32'h0);
      `CHK("result", {24'h0, lv}, rd)
      apb(1'b0, 12'h1C4, 32'h0);
      `CHK("csr", {24'h0, 4'h2, ch}, rd)
      $display("convert %0h done", ch);
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, 12'h1C0, 32'h0);
      `CHK("result", 32'h0, rd)
      apb(1'b0, 12'h1C4, 32'h0);
      `CHK("csr", 32'h0, rd)
      apb(1'b0, 12'h1D0, 32'h0);
      `CHK("slverr", 1'b1, err)
      convert(4'h3, 8'hA5);
      convert(4'hF, 8'hFF);
      convert(4'h0, 8'h00);
      levels[7:0] = 8'h3C;
      apb(1'b0, 12'h1C0, 32'h0);
      `CHK("held", 32'h0, rd)
      fall(n);
      fall(n);
      `CHK("period", 24, n)
      // Lands in the conversion phase, so this is an abort
      apb(1'b1, 12'h1C4, 32'h20);
      apb(1'b0, 12'h1C4, 32'h0);
      `CHK("csr", 32'h20, rd)
      apb(1'b1, 12'h1CC, 32'h1);
      @(negedge ref_clk);
      `CHK("irq", 1'b1, irq)
      apb(1'b1, 12'h1C8, 32'h1);
      @(negedge ref_clk);
      `CHK("irq", 1'b0, irq)
      $display("irq test done");
      apb(1'b1, 12'h1C4, 32'h0);
      repeat (30) @(posedge ref_clk);
      `CHK("sample", 1'b0, sample_connect)
      apb(1'b1, 12'h1C4, 32'h20);
      repeat (5) @(posedge ref_clk);
      halt_mode <= 1'b1;
      @(negedge ref_clk);
      `CHK("on", 1'b0, converter_on)
      $display("power test done");
      finish_test();
   end
endmodule // test_sar_adc_sequencer
`default_nettype wire

/* File: src/sar_adc_sequencer.v */
// Overview of operation
// RULE_01 - Build an 8-bit unsigned result by successive approximation into read-only result.
// RULE_02 - Input at or above high reference gives all ones, with no overflow flag.
// RULE_03 - Input at or below low reference gives a stored result of zero.
// RULE_04 - Sampling phase, then eight approximation steps with capacitor disconnected.
// RULE_05 - While on, sampling and conversion repeat back to back on selected channel.
// RULE_06 - One conversion lasts twelve converter clocks at half the CPU clock.
// RULE_07 - Four-bit channel field in low bits selects one of sixteen inputs.
// RULE_08 - Setting the on bit powers the converter and starts conversion immediately.
// RULE_09 - Every conversion end sets done flag in bit seven; no interrupt is forced.
// RULE_10 - Result holds its value until the next conversion finishes.
// RULE_11 - Control write with on bit set aborts, clears done, restarts conversion.
// RULE_12 - Done flag clears on result read or control/status write.
// RULE_13 - Clearing the on bit switches the converter off and stops conversions.
// RULE_14 - CPU wait mode leaves the converter running as in run mode.
// RULE_15 - Halt disables the converter; software waits for stabilisation after wakeup.
// RULE_16 - Reset clears control/status and result: off, channel zero.
// RULE_17 - Converter clock is an enable every second CPU clock; four ticks sample.
// RULE_18 - Reserved control/status bits are written zero and read as zero.
`timescale 1ns/10ps
`include "sar_adc_defines.vh"
`default_nettype none

module sar_adc_sequencer (
   input wire ref_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   input wire halt_mode,
   input wire comp_in,
   output wire [3:0] channel_select,
   output wire converter_on,
   output wire sample_connect,
   output reg [7:0] dac_code,
   output wire irq
);

   // ==========================================================
   // States and helpers
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SAMPLE = 3'b010;
   localparam [2:0] ST_CONVERT = 3'b100;

   // Trial bit for a converter-clock count of 4..11 (bit 7 down to bit 0)
   function [7:0] sar_bit;
      input [3:0] cnt;
      begin
         sar_bit = 8'h01 << (4'hB - cnt);
      end
   endfunction

   function hit;
      input [11:0] addr;
      input [9:0] idx;
      begin
         hit = (addr == {idx, 2'b00});
      end
   endfunction

   reg [2:0] state_reg;
   reg [3:0] count_reg;
   reg div_reg;
   reg [7:0] result_reg;
   reg on_reg;
   reg [3:0] chan_reg;
   reg done_reg;
   reg irq_status_reg;
   reg irq_mask_reg;

   // ==========================================================
   // Bus decode
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire sel_res = hit(paddr, `RESULT_IDX);
   wire sel_csr = hit(paddr, `CTRL_STATUS_IDX);
   wire sel_ist = hit(paddr, `IRQ_STATUS_IDX);
   wire sel_imk = hit(paddr, `IRQ_MASK_IDX);
   wire mapped = sel_res | sel_csr | sel_ist | sel_imk;
   wire csr_wr = access & pwrite & sel_csr;
   wire res_rd = access & ~pwrite & sel_res;
   wire ist_wr = access & pwrite & sel_ist;
   wire imk_wr = access & pwrite & sel_imk;

   // Zero wait states: every access phase completes at once
   assign pready = 1'b1;

   // Halt overrides the on bit without altering it
   wire active = on_reg & ~halt_mode; // RULE_15 RULE_14
   wire tick = div_reg; // RULE_17
   wire conv_end = active & ~csr_wr & tick & (state_reg == ST_CONVERT) &
                   (count_reg == (`CONV_TICKS - 4'h1));
   wire [7:0] kept = comp_in ? dac_code : (dac_code & ~sar_bit(count_reg));

   // ==========================================================
   // Sequencer
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         count_reg <= 4'h0;
         div_reg <= 1'b0;
         dac_code <= 8'h00;
         result_reg <= `RESULT_RESET; // RULE_16
      end else if (csr_wr) begin
         // Abort whatever is running; restart only if left on
         state_reg <= (pwdata[`ON_BIT] & ~halt_mode) ? ST_SAMPLE : ST_IDLE; // RULE_11 RULE_08
         count_reg <= 4'h0;
         div_reg <= 1'b0;
         dac_code <= 8'h00;
      end else if (!active) begin
         state_reg <= ST_IDLE; // RULE_13
         count_reg <= 4'h0;
         div_reg <= 1'b0;
         dac_code <= 8'h00;
      end else begin
         div_reg <= ~div_reg; // RULE_17
         case (state_reg)
            ST_IDLE: begin
               state_reg <= ST_SAMPLE; // RULE_08
               div_reg <= 1'b0;
            end
            ST_SAMPLE: begin
               if (tick) begin
                  if (count_reg == (`SAMPLE_TICKS - 4'h1)) begin
                     state_reg <= ST_CONVERT; // RULE_04
                     dac_code <= `SAR_FIRST;
                  end
                  count_reg <= count_reg + 4'h1;
               end
            end
            ST_CONVERT: begin
               if (tick) begin
                  if (conv_end) begin
                     // Comparator stuck high yields FFh, stuck low 00h; no overflow bit exists
                     result_reg <= kept; // RULE_01 RULE_02 RULE_03 RULE_10
                     state_reg <= ST_SAMPLE; // RULE_05 RULE_06
                     count_reg <= 4'h0;
                     dac_code <= 8'h00;
                  end else begin
                     dac_code <= kept | sar_bit(count_reg + 4'h1); // RULE_01
                     count_reg <= count_reg + 4'h1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               count_reg <= 4'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // Registers and flags
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         on_reg <= 1'b0; // RULE_16
         chan_reg <= 4'h0;
         done_reg <= 1'b0;
         irq_status_reg <= 1'b0;
         irq_mask_reg <= `IRQ_MASK_RESET;
      end else begin
         if (csr_wr) begin
            on_reg <= pwdata[`ON_BIT]; // RULE_08 RULE_13
            chan_reg <= pwdata[`CHAN_MSB:`CHAN_LSB]; // RULE_07
         end
         // Set wins over clear; a control write aborts so cannot meet an end
         if (conv_end)
            done_reg <= 1'b1; // RULE_09
         else if (csr_wr | res_rd)
            done_reg <= 1'b0; // RULE_12 RULE_11
         if (conv_end)
            irq_status_reg <= 1'b1;
         else if (ist_wr & pwdata[0])
            irq_status_reg <= 1'b0;
         if (imk_wr)
            irq_mask_reg <= pwdata[0];
      end
   end

   // Read data is captured in the setup cycle, so it reflects that edge
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= ~mapped;
         if (sel_res)
            prdata <= {24'h000000, result_reg}; // RULE_01
         else if (sel_csr)
            prdata <= {24'h000000, done_reg, 1'b0, on_reg, 1'b0, chan_reg}; // RULE_18
         else if (sel_ist)
            prdata <= {31'h00000000, irq_status_reg};
         else if (sel_imk)
            prdata <= {31'h00000000, irq_mask_reg};
         else
            prdata <= 32'h00000000;
      end
   end

   // ==========================================================
   // Analog side
   assign channel_select = chan_reg; // RULE_07
   assign converter_on = active; // RULE_13 RULE_15
   assign sample_connect = active & (state_reg == ST_SAMPLE); // RULE_04
   // Mask resets to zero, so by default conversions raise nothing
   assign irq = irq_status_reg & irq_mask_reg; // RULE_09

endmodule // sar_adc_sequencer

`default_nettype wire
